// ===== core/supply_voltage_trip_detector.v
`timescale 1ns/1ps
`include "voltage_detector_map.vh"

module supply_voltage_trip_detector #(
    parameter SETTLE_CYCLES = (`VD_SETTLE_TIME_NS + `VD_CLK_PERIOD_NS - 1) / `VD_CLK_PERIOD_NS
) (
    input  wire        i_core_clk,        // System clock, 10 MHz
    input  wire        i_sys_rst,         // Synchronous reset, active high
    input  wire        i_clk_en,          // Freezes all state while low
    input  wire [3:0]  avs_address,       // Byte address
    input  wire        avs_read,          // Read request
    input  wire        avs_write,         // Write request
    input  wire [31:0] avs_writedata,     // Write data
    input  wire [3:0]  avs_byteenable,    // Byte lanes
    output reg  [31:0] avs_readdata,      // Read data
    output wire        avs_waitrequest,   // Stall until answer is ready
    output reg  [1:0]  avs_response,      // 00 okay, 10 slave error
    input  wire        i_comp_internal,   // Comparator: supply at/above internal tap
    input  wire        i_comp_external,   // Comparator: supply at/above external pin level
    input  wire        i_sleep,           // Device is in sleep
    output reg         o_analog_power_on, // Powers ladder and comparator
    output reg  [3:0]  o_ladder_tap,      // Internal tap selection
    output reg         o_external_sel,    // Routes external trip input to comparator
    output reg         o_irq,             // Interrupt request to the core
    output reg         o_wake,            // Wake request out of sleep
    output reg         o_vector           // Branch to vector after wake
);

    // Settling counter width; wide enough to hold the full count
    // The count is the settle time over the clock period, rounded up,
    // so the detector never arms before the reference has settled
    // A different clock needs a matching settle count at the instance
    localparam CW = (SETTLE_CYCLES > 1) ? $clog2(SETTLE_CYCLES + 1) : 1;

    // One-hot detector states
    // Only the armed state lets a trip reach the event flag
    localparam [2:0] ST_OFF    = 3'b001; // Powered down, stable flag low
    localparam [2:0] ST_SETTLE = 3'b010; // Reference settling, trips ignored
    localparam [2:0] ST_ARMED  = 3'b100; // Reference stable, trips set the event flag

    // Detector sequencing
    reg  [2:0]    state_q;         // Detector state
    reg  [2:0]    state_d;         // Next state
    reg  [CW-1:0] settle_cnt_q;    // Settling countdown
    reg  [CW-1:0] settle_cnt_d;    // Next countdown
    // Control register bits
    reg           trip_direction_select;   // Bit 7
    reg           detector_power_on;       // Bit 4
    reg  [3:0]    trip_level_select;       // Bits 3..0
    reg           reference_stable_flag;   // Bit 5, read-only
    // Flag and enable bits
    reg           voltage_event_flag;      // Sticky event flag
    reg           voltage_event_irq_enable;// Event interrupt enable
    reg           voltage_event_priority;  // Stored priority bit
    reg           global_irq_enable;       // Global enable
    // Bus handshake
    reg           ack_q;           // Answer pending for the current access
    wire          access;          // Request present
    // Register write strobes, one per address
    wire          wr_ctrl;         // Write to control
    wire          wr_flags;        // Write to flags
    wire          wr_en;           // Write to enables
    wire          wr_core;         // Write to core irq control
    // Comparator path
    wire          comp_level;      // Selected comparator output
    wire          trip;            // Trip condition in chosen direction
    wire          clear_event;     // Software clears the event flag

    // Decode for a mapped register address
    function mapped;
        input [3:0] a;
        begin
            mapped = (a == `VD_ADDR_CONTROL) || (a == `VD_ADDR_FLAGS) ||
                     (a == `VD_ADDR_ENABLES) || (a == `VD_ADDR_CORE_IRQ);
        end
    endfunction

    // Decode for the level code that selects the external pin
    // Shared by the comparator mux and the routing output, so the
    // two agree on which source is live, the routing output one edge later
    // The reserved code gets no special decode and uses a ladder tap
    function ext_level;
        input [3:0] lvl;
        begin
            ext_level = (lvl == `VD_LEVEL_EXTERNAL);
        end
    endfunction

    // Any request on the slave
    assign access   = avs_read | avs_write;
    // One wait cycle: answer one edge after the request appears
    // While the clock enable is low nothing is taken, so the slave
    // keeps stalling instead of letting a write slip past unheard
    assign avs_waitrequest = access & (~ack_q | ~i_clk_en);
    // Strobes need ack_q, so a write lands once, at the taken edge
    assign wr_ctrl  = avs_write & ack_q & avs_byteenable[0] & (avs_address == `VD_ADDR_CONTROL);
    assign wr_flags = avs_write & ack_q & avs_byteenable[0] & (avs_address == `VD_ADDR_FLAGS);
    assign wr_en    = avs_write & ack_q & avs_byteenable[0] & (avs_address == `VD_ADDR_ENABLES);
    assign wr_core  = avs_write & ack_q & avs_byteenable[0] & (avs_address == `VD_ADDR_CORE_IRQ);

    // Comparator mux: external pin on the all-ones level
    assign comp_level = ext_level(trip_level_select) ?
                        i_comp_external : i_comp_internal;
    // Direction: set means at/above, clear means at/below
    // Both comparator inputs read high while the supply is at/above
    assign trip = trip_direction_select ? comp_level : ~comp_level;
    // Writing zero to the event bit clears it; writing one does nothing
    assign clear_event = wr_flags & ~avs_writedata[`VD_BIT_EVENT];

    // Handshake tracking
    // High for the one cycle in which the answer stands
    always @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            ack_q <= 1'b0;
        end else if (i_clk_en) begin
            ack_q <= access & ~ack_q;
        end
    end

    // Read data and response, presented at the answering edge
    always @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            avs_readdata <= 32'h0000_0000;
            avs_response <= 2'b00;
        // Load at the first edge so the data stand at the answering edge
        end else if (i_clk_en && access && !ack_q) begin
            avs_readdata <= 32'h0000_0000;
            // Unmapped addresses answer with a slave error and zero data
            avs_response <= mapped(avs_address) ? 2'b00 : 2'b10;
            case (avs_address)
                `VD_ADDR_CONTROL: begin
                    // Bit 6 stays zero
                    avs_readdata[7:0] <= {trip_direction_select, 1'b0,
                                          reference_stable_flag, detector_power_on,
                                          trip_level_select};
                end
                // Event flag in bit 2
                `VD_ADDR_FLAGS: begin
                    avs_readdata[`VD_BIT_EVENT] <= voltage_event_flag;
                end
                // Event enable in bit 2, stored priority in bit 10
                `VD_ADDR_ENABLES: begin
                    avs_readdata[`VD_BIT_EVENT] <= voltage_event_irq_enable;
                    avs_readdata[`VD_BIT_EVENT + 8] <= voltage_event_priority;
                end
                // Global enable in bit 7
                `VD_ADDR_CORE_IRQ: begin
                    avs_readdata[`VD_BIT_GLOBAL_IRQ] <= global_irq_enable;
                end
                default: begin
                    avs_readdata <= 32'h0000_0000;
                end
            endcase
        end
    end

    // Software-written registers
    // Bits 6 and 5 of the control byte have no storage here: the
    // unused bit is a constant zero and the stable flag is owned by
    // the sequencer below
    always @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            // Reset state turns the detector off
            trip_direction_select    <= 1'b0;
            detector_power_on        <= 1'b0;
            trip_level_select        <= `VD_LEVEL_RESET;
            // Interrupt enables start cleared
            voltage_event_irq_enable <= 1'b0;
            voltage_event_priority   <= 1'b0;
            global_irq_enable        <= 1'b0;
        end else if (i_clk_en) begin
            if (wr_ctrl) begin
                // Bit 5 and bit 6 are not writable
                trip_direction_select <= avs_writedata[`VD_BIT_DIRECTION];
                detector_power_on     <= avs_writedata[`VD_BIT_POWER_ON];
                trip_level_select     <= avs_writedata[`VD_LEVEL_MSB:`VD_LEVEL_LSB];
            end
            // Enable and stored priority bit share one write
            if (wr_en) begin
                voltage_event_irq_enable <= avs_writedata[`VD_BIT_EVENT];
                voltage_event_priority   <= avs_writedata[`VD_BIT_EVENT + 8];
            end
            // Global enable lives in the core irq control word
            if (wr_core) begin
                global_irq_enable <= avs_writedata[`VD_BIT_GLOBAL_IRQ];
            end
        end
    end

    // Detector state machine and settling countdown
    // A disable from any state returns to off, so the next enable
    // always passes through a fresh settle
    always @* begin
        state_d      = state_q;
        settle_cnt_d = settle_cnt_q;
        case (state_q)
            // Wait for software to power the detector
            ST_OFF: begin
                if (detector_power_on) begin
                    // Every enable restarts the fixed-time settle
                    state_d      = ST_SETTLE;
                    settle_cnt_d = SETTLE_CYCLES[CW-1:0];
                end
            end
            // Count down; the last count arms the detector
            ST_SETTLE: begin
                if (!detector_power_on) begin
                    state_d = ST_OFF;
                end else if (settle_cnt_q <= {{(CW-1){1'b0}}, 1'b1}) begin
                    state_d      = ST_ARMED;
                    settle_cnt_d = {CW{1'b0}};
                end else begin
                    settle_cnt_d = settle_cnt_q - {{(CW-1){1'b0}}, 1'b1};
                end
            end
            // Stay armed until software powers down
            ST_ARMED: begin
                if (!detector_power_on) begin
                    state_d = ST_OFF;
                end
            end
            default: begin
                state_d      = ST_OFF;
                settle_cnt_d = {CW{1'b0}};
            end
        endcase
    end

    // State registers and stable flag; disable clears stable
    // The stable flag follows the next state, so it rises with the
    // armed state and falls with the disable
    always @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            state_q               <= ST_OFF;
            settle_cnt_q          <= {CW{1'b0}};
            reference_stable_flag <= 1'b0;
        end else if (i_clk_en) begin
            state_q               <= state_d;
            settle_cnt_q          <= settle_cnt_d;
            reference_stable_flag <= (state_d == ST_ARMED);
        end
    end

    // Sticky event flag; a trip in the clearing cycle wins
    // A clear that meets a trip loses, so no crossing is lost between
    // a read of the flag and the clear that follows it
    always @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            voltage_event_flag <= 1'b0;
        end else if (i_clk_en) begin
            // Only armed and powered, also while in sleep
            if (reference_stable_flag && detector_power_on && trip) begin
                voltage_event_flag <= 1'b1;
            // Software clear, only with no trip present
            end else if (clear_event) begin
                voltage_event_flag <= 1'b0;
            end
        end
    end

    // Analog controls, interrupt, wake and vector outputs
    // All registered, one edge behind the bits that drive them
    always @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            // Everything off and quiet out of reset
            o_analog_power_on <= 1'b0;
            o_ladder_tap      <= 4'h0;
            o_external_sel    <= 1'b0;
            o_irq             <= 1'b0;
            o_wake            <= 1'b0;
            o_vector          <= 1'b0;
        end else if (i_clk_en) begin
            // Ladder and comparator follow the control register
            o_analog_power_on <= detector_power_on;
            o_ladder_tap      <= trip_level_select;
            o_external_sel    <= ext_level(trip_level_select);
            // Both enables needed for an interrupt
            o_irq    <= voltage_event_flag & voltage_event_irq_enable &
                        global_irq_enable;
            // Wake from sleep on the event flag
            o_wake   <= i_sleep & voltage_event_flag & voltage_event_irq_enable;
            // Vector only when globally enabled
            o_vector <= i_sleep & voltage_event_flag & voltage_event_irq_enable &
                        global_irq_enable;
        end
    end

endmodule

// ===== dv/supply_voltage_trip_detector_tb_top.sv
`timescale 1ns/1ps
module supply_voltage_trip_detector_tb_top;
    typedef struct {logic [3:0] a; logic [31:0] w; logic [31:0] r;} row_t;
    logic        i_core_clk = 1'b0;                // 10 MHz system clock
    logic        i_sys_rst = 1'b1;                 // Held for three cycles
    logic [3:0]  avs_address = 4'h0;               // Bus request fields
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata, rd;                 // Bus answer and last read
    logic        avs_waitrequest;
    logic [1:0]  avs_response;
    logic        i_comp_internal = 1'b1;           // Comparator inputs
    logic        i_comp_external = 1'b1;
    logic        i_sleep = 1'b0;
    logic        o_analog_power_on, o_external_sel, o_irq, o_wake, o_vector;
    logic [3:0]  o_ladder_tap, lvl;                // Tap output and level in test
    logic        dir;                              // Direction in test
    int          errors = 0;
    int          n_compared = 0;
    int          cycles = 0;
    // Register writes beside the readback they should give
    row_t rows[6] = '{'{4'h0, 32'h0000_00EF, 32'h0000_008F}, '{4'h0, 32'h0000_0040, 32'h0},
        '{4'h8, 32'h0000_0404, 32'h0000_0404}, '{4'hC, 32'h0000_0080, 32'h0000_0080},
        '{4'h4, 32'h0000_0004, 32'h0}, '{4'h2, 32'h0000_00FF, 32'h0}};
    supply_voltage_trip_detector #(.SETTLE_CYCLES(4)) i_supply_voltage_trip_detector (
        .i_core_clk, .i_sys_rst, .i_clk_en(1'b1), .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .avs_response,
        .i_comp_internal, .i_comp_external, .i_sleep, .o_analog_power_on, .o_ladder_tap,
        .o_external_sel, .o_irq, .o_wake, .o_vector);
    // Clock generator
    initial forever #50 i_core_clk = ~i_core_clk;
    // Hang guard
    always @(posedge i_core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            errors++;
            print_verdict();
        end
    end
    task automatic print_verdict;
        if (errors == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // One bus access, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] w);
        @(posedge i_core_clk);
        avs_read <= !wr;
        avs_write <= wr;
        avs_address <= a;
        avs_writedata <= w;
        do @(posedge i_core_clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic expect_reg(input string name, input logic [3:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        check(name, rd, exp);
    endtask
    initial begin
        repeat (3) @(posedge i_core_clk);
        i_sys_rst <= 1'b0;
        expect_reg("reset control", 4'h0, 32'h0000_0005);
        foreach (rows[k]) begin
            bus(1'b1, rows[k].a, rows[k].w);
            expect_reg("readback", rows[k].a, rows[k].r);
        end
        // Trip present while settling: no flag, no irq
        i_comp_internal <= 1'b0;
        bus(1'b1, 4'h0, 32'h0000_001A);
        expect_reg("flag early", 4'h4, 32'h0);
        check("irq early", 32'(o_irq), 32'h0);
        repeat (6) @(posedge i_core_clk);
        expect_reg("stable", 4'h0, 32'h0000_003A);
        expect_reg("flag", 4'h4, 32'h0000_0004);
        check("irq", 32'(o_irq), 32'h1);
        bus(1'b1, 4'h4, 32'h0);
        expect_reg("set beats clear", 4'h4, 32'h0000_0004);
        i_comp_internal <= 1'b1;
        bus(1'b1, 4'h4, 32'h0);
        expect_reg("cleared", 4'h4, 32'h0);
        check("irq gone", 32'(o_irq), 32'h0);
        // Both directions, internal tap and external pin
        for (int m = 0; m < 4; m++) begin
            dir = m[0];
            lvl = m[1] ? 4'hF : 4'hA;
            bus(1'b1, 4'h0, 32'h0);
            expect_reg("sticky", 4'h4, (m == 0) ? 32'h0 : 32'h4);
            i_comp_internal <= !dir;
            i_comp_external <= !dir;
            bus(1'b1, 4'h0, {28'h0, lvl});
            bus(1'b1, 4'h0, {24'h0, dir, 3'b000, lvl});
            bus(1'b1, 4'h0, {24'h0, dir, 3'b001, lvl});
            expect_reg("restart", 4'h0, {24'h0, dir, 3'b001, lvl});
            repeat (6) @(posedge i_core_clk);
            check("power", 32'(o_analog_power_on), 32'h1);
            bus(1'b1, 4'h4, 32'h0);
            expect_reg("no trip", 4'h4, 32'h0);
            if (m[1]) i_comp_external <= dir;
            else i_comp_internal <= dir;
            repeat (3) @(posedge i_core_clk);
            expect_reg("trip", 4'h4, 32'h0000_0004);
            check("route", 32'(o_external_sel), 32'(m[1]));
            check("tap", 32'(o_ladder_tap), 32'(lvl));
            check("awake no wake", 32'(o_wake), 32'h0);
        end
        // Trip in sleep with global enable off, then on
        i_comp_external <= 1'b0;
        bus(1'b1, 4'hC, 32'h0);
        bus(1'b1, 4'h4, 32'h0);
        i_sleep <= 1'b1;
        repeat (2) @(posedge i_core_clk);
        i_comp_external <= 1'b1;
        repeat (3) @(posedge i_core_clk);
        check("wake", 32'(o_wake), 32'h1);
        check("vector off", 32'(o_vector), 32'h0);
        check("irq off", 32'(o_irq), 32'h0);
        bus(1'b1, 4'hC, 32'h0000_0080);
        repeat (2) @(posedge i_core_clk);
        check("vector on", 32'(o_vector), 32'h1);
        // Reset in mid-run turns the detector off
        i_sys_rst <= 1'b1;
        repeat (3) @(posedge i_core_clk);
        i_sys_rst <= 1'b0;
        check("power off", 32'(o_analog_power_on), 32'h0);
        expect_reg("control after reset", 4'h0, 32'h0000_0005);
        print_verdict();
    end
endmodule

// ===== dv/voltage_detector_assertions.sv
`timescale 1ns/1ps
module voltage_detector_assertions #(
    parameter SETTLE_CYCLES = 4
) (
    input wire        i_core_clk,
    input wire        i_sys_rst,
    input wire [3:0]  avs_address,
    input wire        avs_read,
    input wire        avs_write,
    input wire [31:0] avs_writedata,
    input wire [31:0] avs_readdata,
    input wire        avs_waitrequest,
    input wire [1:0]  avs_response,
    input wire        o_analog_power_on,
    input wire        o_external_sel,
    input wire        o_irq,
    input wire        o_wake,
    input wire        o_vector
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_sys_rst);
    logic       pwr_q;                             // Shadow of the power enable
    logic [3:0] lvl_q;                             // Shadow of the trip level
    logic       ie_q;                              // Shadow of the event irq enable
    logic       gie_q;                             // Shadow of the global enable
    wire        taken = avs_write && !avs_waitrequest; // Write lands at this edge
    // Shadows follow every write that the slave takes
    always @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            pwr_q <= 1'b0;
            lvl_q <= 4'h5;
            ie_q  <= 1'b0;
            gie_q <= 1'b0;
        end else if (taken) begin
            if (avs_address == 4'h0) pwr_q <= avs_writedata[4];
            if (avs_address == 4'h0) lvl_q <= avs_writedata[3:0];
            if (avs_address == 4'h8) ie_q <= avs_writedata[2];
            if (avs_address == 4'hC) gie_q <= avs_writedata[7];
        end
    end
    a_wait_one_cycle: assert property ((avs_read || avs_write) && !$past(avs_read || avs_write)
        |-> avs_waitrequest ##1 !avs_waitrequest) else $error("answer not one cycle late");
    a_response_map: assert property ((avs_read || avs_write) && !avs_waitrequest
        |-> avs_response == ((avs_address[1:0] == 2'b00) ? 2'b00 : 2'b10))
        else $error("wrong response code");
    a_unused_bit_zero: assert property (avs_read && !avs_waitrequest && avs_address == 4'h0
        |-> !avs_readdata[6]) else $error("control bit 6 reads one");
    a_reset_quiet: assert property (disable iff (1'b0) i_sys_rst
        |=> !(o_irq || o_wake || o_vector || o_analog_power_on)) else $error("output after reset");
    a_power_follows: assert property (pwr_q == $past(pwr_q) && pwr_q == $past(pwr_q, 2)
        |-> o_analog_power_on == pwr_q) else $error("power output differs from enable");
    a_external_route: assert property (o_external_sel
        |-> lvl_q == 4'hF || $past(lvl_q) == 4'hF) else $error("external route without 1111");
    a_irq_gated: assert property (o_irq |-> (ie_q && gie_q) || $past(ie_q && gie_q))
        else $error("irq without both enables");
    a_vector_gated: assert property (o_vector |-> gie_q || $past(gie_q))
        else $error("vector without global enable");
endmodule
bind supply_voltage_trip_detector voltage_detector_assertions #(.SETTLE_CYCLES(SETTLE_CYCLES))
    i_voltage_detector_assertions (.i_core_clk, .i_sys_rst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .avs_response, .o_analog_power_on,
    .o_external_sel, .o_irq, .o_wake, .o_vector);

// ===== include/voltage_detector_map.vh
`ifndef VOLTAGE_DETECTOR_MAP_VH
`define VOLTAGE_DETECTOR_MAP_VH

// Register byte addresses on the Avalon-MM slave
`define VD_ADDR_CONTROL      4'h0
`define VD_ADDR_FLAGS        4'h4
`define VD_ADDR_ENABLES      4'h8
`define VD_ADDR_CORE_IRQ     4'hC

// Control register field positions
`define VD_BIT_DIRECTION     7
`define VD_BIT_UNUSED6       6
`define VD_BIT_REF_STABLE    5
`define VD_BIT_POWER_ON      4
`define VD_LEVEL_MSB         3
`define VD_LEVEL_LSB         0

// Flag, enable and core irq bit positions
`define VD_BIT_EVENT         2
`define VD_BIT_GLOBAL_IRQ    7

// Reset values and the special level codes
`define VD_CONTROL_RESET     8'h05
`define VD_LEVEL_RESET       4'h5
`define VD_LEVEL_EXTERNAL    4'hF
`define VD_LEVEL_RESERVED    4'h0

// Settling time in nanoseconds and the clock period
`define VD_SETTLE_TIME_NS    20000
`define VD_CLK_PERIOD_NS     100

`endif
